// ---- common/dsw_pkg.sv ----
// Purpose: shared constants for the deep-sleep wake timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses

package dsw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_TIMING   = 8'h00;
  localparam logic [7:0] OFS_SLEEP_DUR     = 8'h04;
  localparam logic [7:0] OFS_SLEEP_ELAPSED = 8'h08;
  localparam logic [7:0] OFS_SLEEP_CTRL    = 8'h0C;
  localparam logic [7:0] OFS_CORE_CTRL2    = 8'h10;
  localparam logic [7:0] OFS_GEN_CTRL      = 8'h14;
  localparam logic [7:0] OFS_MEM_BASE      = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h24;
  localparam logic [7:0] OFS_SLOT_COUNT    = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_ASSERT_LEAD   = 0;
  localparam int POS_DEASSERT_LEAD = 8;
  localparam int POS_EXT_LEN       = 16;
  localparam int POS_LP_SEL        = 24;
  localparam int POS_SLEEP_REQ     = 0;
  localparam int POS_EXT_IGNORE    = 1;
  localparam int POS_ASLEEP        = 2;
  localparam int POS_PD_ALLOWED    = 0;
  localparam int POS_CORE_CLK_EN   = 1;
  localparam int POS_RADIO_SLEEP   = 2;
  localparam int POS_EXT_WAKE      = 0;
  localparam int POS_EV_WAKE       = 0;
  localparam int POS_EV_EXIT       = 1;
  localparam int NUM_EVENTS        = 2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_ASSERT_LEAD   = 8'h04;
  localparam logic [7:0]  RST_DEASSERT_LEAD = 8'h01;
  localparam logic [7:0]  RST_EXT_LEN       = 8'h02;
  localparam logic [1:0]  RST_LP_SEL        = 2'h2;
  localparam logic [31:0] RST_MEM_BASE      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // slot reference on the low-power tick
  // ----------------------------------------------------------------
  localparam int SLOT_TIME_US = 625;
  localparam int LP_FREQ_15K  = 15000;
  localparam int LP_FREQ_32K  = 32000;
  localparam int LP_FREQ_32K7 = 32768;
  localparam int US_PER_S     = 1000000;
  localparam int SLOT_ACC_W   = 25;
  localparam logic [1:0] LP_SEL_15K  = 2'h0;
  localparam logic [1:0] LP_SEL_32K  = 2'h1;

endpackage

// ---- common/dsw_irq_if.sv ----
// Purpose: event and register path between timer core and interrupt block
// Assumes: single clock domain
// Notes:   write strobes are one-cycle pulses

`timescale 1ns/10ps

interface dsw_irq_if;
  import dsw_pkg::*;
  logic [NUM_EVENTS-1:0] events;
  logic                  enableWe;
  logic                  clearWe;
  logic [NUM_EVENTS-1:0] wdata;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_EVENTS-1:0] enable;
  logic                  irq;

  modport src  (output events, enableWe, clearWe, wdata, input status, enable, irq);
  modport sink (input events, enableWe, clearWe, wdata, output status, enable, irq);
endinterface

// ---- logic/dsw_sync3.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to core_clk
// Notes:   output changes only when stages two and three agree

`timescale 1ns/10ps

module dsw_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // pins
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] held;
  } dsw_sync_t;

  dsw_sync_t r;
  dsw_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = asyncIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.held[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign syncOut = r.held;

endmodule

// ---- logic/dsw_irq_ctrl.sv ----
// Purpose: sticky event status, enable mask and one level interrupt
// Assumes: strobes come from the register decoder of the timer core
// Notes:   an event in the clearing cycle stays set

`timescale 1ns/10ps

module dsw_irq_ctrl (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // event path
  dsw_irq_if.sink   port
);
  import dsw_pkg::*;

  typedef struct packed {
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] enable;
  } dsw_irq_t;

  dsw_irq_t r;
  dsw_irq_t next_r;

  always_comb begin
    next_r = r;
    if (port.clearWe) begin
      next_r.status = r.status & ~port.wdata;
    end
    // set after clear so a coincident event wins
    next_r.status = next_r.status | port.events;
    if (port.enableWe) begin
      next_r.enable = port.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port.status = r.status;
  assign port.enable = r.enable;
  assign port.irq    = |(r.status & r.enable);

endmodule

// ---- logic/dsw_wake_timer.sv ----
// Purpose: deep-sleep entry and wake sequencing for the baseband core
// Assumes: low-power tick arrives on a pin, far slower than core_clk
// Notes:   APB slave with one wait state; pslverr on unmapped offsets

`timescale 1ns/10ps

// Behaviour
// - exit always shows wake interrupt first, sleep-exit interrupt after
// - wake interrupt rises when remaining ticks equal the assert lead
// - wake interrupt falls when remaining ticks equal the deassert lead
// - a short assert lead still wakes; elapsed time then exceeds duration
// - external wake holds interrupt for pulse length minus deassert lead, or one tick if that is not positive
// - writing the external wake bit while switching or asleep raises the wake interrupt at once, unless ignored
// - asleep, the slot reference runs on the low-power tick
// - powerdown-allowed flag set once tick carries the time base
// - shared memory accesses are offset by the programmable base
// - after expiry, exit waits until core is clocked and powered
// - held external wake refuses sleep entry unless ignored
module dsw_wake_timer #(
  parameter int DUR_W = 24
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pins
  input  wire logic                  lowPowerTickClock,
  input  wire logic                  radioDomainUp,
  // interrupts
  output logic                       lpWakeIrq,
  output logic                       sleepExitIrq,
  output logic                       irq,
  // power control
  output logic                       coreMasterClockEnable,
  output logic                       radioSleep,
  // shared memory master address
  input  wire logic                  memReqValid,
  input  wire logic [15:0]           memReqOffset,
  output logic      [31:0]           memAddr,
  output logic                       memAddrValid
);
  import dsw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DSW_IDLE,
    DSW_SWITCHING,
    DSW_ASLEEP,
    DSW_WAIT_CORE
  } dsw_state_t;

  typedef struct packed {
    dsw_state_t              st;
    logic                    apbAck;
    logic [31:0]             rdata;
    logic                    slvErr;
    logic [7:0]              assertLead;
    logic [7:0]              deassertLead;
    logic [7:0]              extLen;
    logic [1:0]              lpSel;
    logic [DUR_W-1:0]        duration;
    logic [DUR_W-1:0]        elapsed;
    logic [DUR_W-1:0]        elapsedStat;
    logic                    sleepReq;
    logic                    extIgnore;
    logic                    coreClkEn;
    logic                    radioSleep;
    logic                    extWake;
    logic                    pdAllowed;
    logic [31:0]             memBase;
    logic [31:0]             memAddr;
    logic                    memValid;
    logic                    lpWake;
    logic                    lpWakePrev;
    logic                    wakeSeen;
    logic                    extActive;
    logic [7:0]              extCnt;
    logic                    sleepExit;
    logic                    tickPrev;
    logic [SLOT_ACC_W-1:0]   slotAcc;
    logic [15:0]             slotCount;
  } dsw_core_t;

  dsw_core_t r;
  dsw_core_t next_r;

  dsw_irq_if irqBus ();

  logic [1:0] pinSync;
  logic       tick;
  logic       radioUp;
  logic       apbAccess;
  logic       apbWrite;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SLOT_ACC_W-1:0] slotThreshold(input logic [1:0] sel);
    if (sel == LP_SEL_15K) begin
      slotThreshold = SLOT_ACC_W'(LP_FREQ_15K * SLOT_TIME_US);
    end else if (sel == LP_SEL_32K) begin
      slotThreshold = SLOT_ACC_W'(LP_FREQ_32K * SLOT_TIME_US);
    end else begin
      slotThreshold = SLOT_ACC_W'(LP_FREQ_32K7 * SLOT_TIME_US);
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_WAKE_TIMING) || (a == OFS_SLEEP_DUR) || (a == OFS_SLEEP_ELAPSED)
          || (a == OFS_SLEEP_CTRL) || (a == OFS_CORE_CTRL2) || (a == OFS_GEN_CTRL)
          || (a == OFS_MEM_BASE) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_CLEAR)
          || (a == OFS_IRQ_ENABLE) || (a == OFS_SLOT_COUNT);
  endfunction

  // external wake that is not masked by the ignore bit
  function automatic logic extHeld(input dsw_core_t s);
    extHeld = s.extWake && !s.extIgnore;
  endfunction

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  dsw_sync3 #(
    .W (2)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .asyncIn  ({radioDomainUp, lowPowerTickClock}),
    .syncOut  (pinSync)
  );

  assign radioUp = pinSync[1];
  assign tick    = pinSync[0] && !r.tickPrev;

  // ----------------------------------------------------------------
  // interrupt block
  // ----------------------------------------------------------------
  dsw_irq_ctrl u_irq (
    .core_clk (core_clk),
    .srst     (srst),
    .port     (irqBus.sink)
  );

  assign apbAccess = psel && penable;
  assign apbWrite  = apbAccess && r.apbAck && pwrite;

  assign irqBus.events   = {r.sleepExit, r.lpWake && !r.lpWakePrev};
  assign irqBus.enableWe = apbWrite && (paddr == OFS_IRQ_ENABLE);
  assign irqBus.clearWe  = apbWrite && (paddr == OFS_IRQ_CLEAR);
  assign irqBus.wdata    = pwdata[NUM_EVENTS-1:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [DUR_W-1:0] nextElapsed;
    logic [DUR_W-1:0] remaining;
    logic [7:0]       extSpan;
    logic [SLOT_ACC_W-1:0] accSum;
    nextElapsed = r.elapsed + DUR_W'(1);
    remaining   = r.duration - nextElapsed;
    extSpan     = (r.extLen > r.deassertLead) ? (r.extLen - r.deassertLead) : 8'h01;
    accSum      = r.slotAcc + SLOT_ACC_W'(US_PER_S);
    next_r            = r;
    next_r.tickPrev   = pinSync[0];
    next_r.lpWakePrev = r.lpWake;
    next_r.sleepExit  = 1'b0;
    next_r.memValid   = memReqValid;

    // bus master address is base plus offset
    if (memReqValid) begin
      next_r.memAddr = r.memBase + {16'h0000, memReqOffset};
    end

    // apb: access phase takes one wait state
    if (apbAccess && !r.apbAck) begin
      next_r.apbAck = 1'b1;
      next_r.slvErr = !mapped(paddr);
      next_r.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFS_WAKE_TIMING: begin
            next_r.rdata = {6'h00, r.lpSel, r.extLen, r.deassertLead, r.assertLead};
          end
          OFS_SLEEP_DUR:     next_r.rdata = 32'(r.duration);
          OFS_SLEEP_ELAPSED: next_r.rdata = 32'(r.elapsedStat);
          OFS_SLEEP_CTRL: begin
            next_r.rdata = {29'h0, (r.st != DSW_IDLE), r.extIgnore, r.sleepReq};
          end
          OFS_CORE_CTRL2: begin
            next_r.rdata = {29'h0, r.radioSleep, r.coreClkEn, r.pdAllowed};
          end
          OFS_GEN_CTRL:   next_r.rdata = {31'h0, r.extWake};
          OFS_MEM_BASE:   next_r.rdata = r.memBase;
          OFS_IRQ_STATUS: next_r.rdata = 32'(irqBus.status);
          OFS_IRQ_ENABLE: next_r.rdata = 32'(irqBus.enable);
          OFS_SLOT_COUNT: next_r.rdata = {16'h0000, r.slotCount};
          default:        next_r.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      next_r.apbAck = 1'b0;
    end

    // register writes take effect at the pready edge
    if (apbWrite) begin
      case (paddr)
        OFS_WAKE_TIMING: begin
          next_r.assertLead   = pwdata[POS_ASSERT_LEAD +: 8];
          next_r.deassertLead = pwdata[POS_DEASSERT_LEAD +: 8];
          next_r.extLen       = pwdata[POS_EXT_LEN +: 8];
          next_r.lpSel        = pwdata[POS_LP_SEL +: 2];
        end
        OFS_SLEEP_DUR: next_r.duration = pwdata[DUR_W-1:0];
        OFS_SLEEP_CTRL: begin
          next_r.sleepReq  = pwdata[POS_SLEEP_REQ];
          next_r.extIgnore = pwdata[POS_EXT_IGNORE];
        end
        OFS_CORE_CTRL2: begin
          next_r.coreClkEn  = pwdata[POS_CORE_CLK_EN];
          next_r.radioSleep = pwdata[POS_RADIO_SLEEP];
        end
        OFS_GEN_CTRL: begin
          next_r.extWake = pwdata[POS_EXT_WAKE];
        end
        OFS_MEM_BASE: next_r.memBase = pwdata;
        default: begin
        end
      endcase
    end

    // slot reference runs only while the tick carries the time base
    if (tick && (r.st != DSW_IDLE)) begin
      if (accSum >= slotThreshold(r.lpSel)) begin
        next_r.slotAcc   = accSum - slotThreshold(r.lpSel);
        next_r.slotCount = r.slotCount + 16'h0001;
      end else begin
        next_r.slotAcc = accSum;
      end
    end

    // external wake pulse counted in low-power ticks
    if (tick && r.extActive) begin
      if (r.extCnt <= 8'h01) begin
        next_r.extActive = 1'b0;
        next_r.lpWake    = 1'b0;
      end else begin
        next_r.extCnt = r.extCnt - 8'h01;
      end
    end

    case (r.st)
      DSW_IDLE: begin
        if (r.sleepReq) begin
          if (extHeld(r)) begin
            // refused entry is reported by the request bit falling
            next_r.sleepReq = 1'b0;
          end else begin
            next_r.st       = DSW_SWITCHING;
            next_r.elapsed  = '0;
            next_r.wakeSeen = 1'b0;
            next_r.slotAcc  = '0;
          end
        end
      end
      DSW_SWITCHING: begin
        if (tick) begin
          next_r.pdAllowed = 1'b1;
          next_r.st        = DSW_ASLEEP;
        end
      end
      DSW_ASLEEP: begin
        if (tick) begin
          next_r.elapsed = nextElapsed;
          if ((remaining == DUR_W'(r.assertLead)) && (r.assertLead != 8'h00)) begin
            next_r.lpWake   = 1'b1;
            next_r.wakeSeen = 1'b1;
          end
          if ((remaining == DUR_W'(r.deassertLead)) && r.lpWake) begin
            next_r.lpWake = 1'b0;
          end
          if (nextElapsed >= r.duration) begin
            next_r.st = DSW_WAIT_CORE;
            // a lead too short to fire still gives one wake tick
            if (!r.wakeSeen || next_r.lpWake) begin
              next_r.lpWake    = 1'b1;
              next_r.wakeSeen  = 1'b1;
              next_r.extActive = 1'b1;
              next_r.extCnt    = 8'h01;
            end
          end
        end
      end
      DSW_WAIT_CORE: begin
        if (tick) begin
          next_r.elapsed = nextElapsed;
        end
        // exit only after the wake pulse ended and the core is back
        if (r.wakeSeen && !r.lpWake && !r.extActive && r.coreClkEn && radioUp
            && !r.radioSleep) begin
          next_r.st          = DSW_IDLE;
          next_r.elapsedStat = r.elapsed;
          next_r.sleepExit   = 1'b1;
          next_r.sleepReq    = 1'b0;
          next_r.pdAllowed   = 1'b0;
        end
      end
      default: begin
        next_r.st = DSW_IDLE;
      end
    endcase

    // writing the wake bit moves to DSW_WAIT_CORE, where elapsed keeps counting ticks, and raises the interrupt
    if (apbWrite && (paddr == OFS_GEN_CTRL) && pwdata[POS_EXT_WAKE] && !r.extWake
        && !r.extIgnore && ((r.st == DSW_SWITCHING) || (r.st == DSW_ASLEEP))) begin
      next_r.lpWake    = 1'b1;
      next_r.wakeSeen  = 1'b1;
      next_r.extActive = 1'b1;
      next_r.extCnt    = extSpan;
      next_r.pdAllowed = 1'b1;
      next_r.st        = DSW_WAIT_CORE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r              <= '0;
      r.st           <= DSW_IDLE;
      r.assertLead   <= RST_ASSERT_LEAD;
      r.deassertLead <= RST_DEASSERT_LEAD;
      r.extLen       <= RST_EXT_LEN;
      r.lpSel        <= RST_LP_SEL;
      r.memBase      <= RST_MEM_BASE;
      r.coreClkEn    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                = r.rdata;
  assign pready                = r.apbAck;
  assign pslverr               = r.apbAck && r.slvErr;
  assign lpWakeIrq             = r.lpWake;
  assign sleepExitIrq          = r.sleepExit;
  assign irq                   = irqBus.irq;
  assign coreMasterClockEnable = r.coreClkEn;
  assign radioSleep            = r.radioSleep;
  assign memAddr               = r.memAddr;
  assign memAddrValid          = r.memValid;

endmodule

// ---- testbench/dsw_wake_timer_checker.sv ----
// Purpose: port-level checks of the deep-sleep wake timer
// Assumes: one clock, srst synchronous active high
// Notes:   helper logic mirrors the shared memory base register

`timescale 1ns/10ps

module dsw_wake_timer_checker
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and outputs
  input wire logic        lowPowerTickClock,
  input wire logic        radioDomainUp,
  input wire logic        lpWakeIrq,
  input wire logic        sleepExitIrq,
  input wire logic        irq,
  input wire logic        coreMasterClockEnable,
  input wire logic        radioSleep,
  input wire logic        memReqValid,
  input wire logic [15:0] memReqOffset,
  input wire logic [31:0] memAddr,
  input wire logic        memAddrValid
);
  logic [31:0] baseCopy;
  logic        wakeSeen;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      baseCopy <= 32'h0000_0000;
      wakeSeen <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == OFS_MEM_BASE) begin
        baseCopy <= pwdata;
      end
      // cleared only by an exit, so a second exit needs a fresh wake
      if (lpWakeIrq) begin
        wakeSeen <= 1'b1;
      end else if (sleepExitIrq) begin
        wakeSeen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_err_unmapped: assert property (pready && paddr > OFS_SLOT_COUNT |-> pslverr)
    else $error("unmapped access without error");
  a_clock_enable_write: assert property (
    psel && penable && pready && pwrite && paddr == OFS_CORE_CTRL2 |=>
      coreMasterClockEnable == $past(pwdata[POS_CORE_CLK_EN])
      && radioSleep == $past(pwdata[POS_RADIO_SLEEP]))
    else $error("power control bits not written");
  a_mem_valid_follow: assert property (memReqValid |=> memAddrValid)
    else $error("address valid not delayed request");
  a_mem_addr_base: assert property (
    memReqValid && !(pready && pwrite) |=>
      memAddr == baseCopy + {16'h0000, $past(memReqOffset)})
    else $error("memory address not base plus offset");
  a_exit_powered: assert property (
    sleepExitIrq |-> coreMasterClockEnable && !radioSleep && !lpWakeIrq)
    else $error("exit while core unclocked or wake high");
  a_exit_after_wake: assert property (sleepExitIrq |-> wakeSeen)
    else $error("exit without wake interrupt first");

  c_wake: cover property ($rose(lpWakeIrq));
  c_exit: cover property (sleepExitIrq);
  c_err: cover property (pready && pslverr);
endmodule

bind dsw_wake_timer dsw_wake_timer_checker chk_u (.core_clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lowPowerTickClock,
  .radioDomainUp, .lpWakeIrq, .sleepExitIrq, .irq, .coreMasterClockEnable,
  .radioSleep, .memReqValid, .memReqOffset, .memAddr, .memAddrValid);

// ---- testbench/dsw_wake_timer_tb_top.sv ----
// Purpose: self-checking bench for the deep-sleep wake timer
// Assumes: ticks far slower than core_clk, ten cycles high and low
// Notes:   the switching tick is elapsed 0, each later tick k is elapsed k

`timescale 1ns/10ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module dsw_wake_timer_tb_top;
  import dsw_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        lowPowerTickClock = 1'b0;
  logic        radioDomainUp = 1'b1;
  logic        memReqValid = 1'b0;
  logic [15:0] memReqOffset = 16'h0;
  logic [31:0] prdata, memAddr, rdv, seed = 32'h51, base, off;
  logic        pready, pslverr, lpWakeIrq, sleepExitIrq, irq, errv;
  logic        coreMasterClockEnable, radioSleep, memAddrValid;
  int          error_cnt = 0, tests_run = 0, cyc = 0, exitCnt = 0;

  dsw_wake_timer #(.DUR_W(24)) dut_u (.core_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lowPowerTickClock, .radioDomainUp,
    .lpWakeIrq, .sleepExitIrq, .irq, .coreMasterClockEnable, .radioSleep,
    .memReqValid, .memReqOffset, .memAddr, .memAddrValid);

  initial forever #12.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask

  task automatic tick();
    @(posedge core_clk);
    lowPowerTickClock <= 1'b1;
    repeat (10) @(posedge core_clk);
    lowPowerTickClock <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask

  // model: wake high from remaining==assert lead down to deassert lead
  task automatic run(input int d, input int al, input int dl, input int k0, input int k1);
    for (int k = k0; k <= k1; k++) begin
      tick();
      `CHK(lpWakeIrq, (al > 0 && d - k <= al && d - k > dl) || (al == 0 && k == d))
    end
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (sleepExitIrq === 1'b1) exitCnt++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(OFS_WAKE_TIMING, 32'h0202_0104);
    rd(OFS_CORE_CTRL2, 32'h0000_0002);
    rd(OFS_IRQ_CLEAR, 32'h0);
    rd(8'h2C, 32'h0);
    `CHK(errv, 1'b1)
    $display("test defaults done");
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_WAKE_TIMING, 32'h0202_0104);
    wr(OFS_SLEEP_DUR, 32'hA);
    wr(OFS_SLEEP_CTRL, 32'h1);
    run(10, 4, 1, 0, 0);
    rd(OFS_CORE_CTRL2, 32'h3);
    run(10, 4, 1, 1, 10);
    `CHK(exitCnt, 1)
    rd(OFS_SLEEP_ELAPSED, 32'hA);
    rd(OFS_CORE_CTRL2, 32'h2);
    rd(OFS_IRQ_STATUS, 32'h3);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLEAR, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h1);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_CLEAR, 32'h2);
    rd(OFS_IRQ_STATUS, 32'h0);
    $display("test timed wake done");
    wr(OFS_WAKE_TIMING, 32'h0202_0100);
    wr(OFS_SLEEP_DUR, 32'h5);
    wr(OFS_SLEEP_CTRL, 32'h1);
    run(5, 0, 1, 0, 0);
    wr(OFS_CORE_CTRL2, 32'h4);
    radioDomainUp <= 1'b0;
    run(5, 0, 1, 1, 6);
    `CHK({coreMasterClockEnable, radioSleep}, 2'b01)
    wr(OFS_CORE_CTRL2, 32'h2);
    repeat (20) @(posedge core_clk);
    `CHK(exitCnt, 1)
    radioDomainUp <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK(exitCnt, 2)
    rd(OFS_SLEEP_ELAPSED, 32'h6);
    $display("test late exit done");
    wr(OFS_WAKE_TIMING, 32'h0203_0104);
    wr(OFS_SLEEP_DUR, 32'h64);
    wr(OFS_SLEEP_CTRL, 32'h1);
    tick();
    wr(OFS_GEN_CTRL, 32'h1);
    @(posedge core_clk);
    #1;
    `CHK(lpWakeIrq, 1'b1)
    tick();
    `CHK(lpWakeIrq, 1'b1)
    tick();
    `CHK(lpWakeIrq, 1'b0)
    `CHK(exitCnt, 3)
    wr(OFS_SLEEP_CTRL, 32'h1);
    rd(OFS_SLEEP_CTRL, 32'h0);
    wr(OFS_SLEEP_DUR, 32'h6);
    wr(OFS_SLEEP_CTRL, 32'h2);
    wr(OFS_SLEEP_CTRL, 32'h3);
    rd(OFS_SLEEP_CTRL, 32'h7);
    run(6, 4, 1, 0, 6);
    `CHK(exitCnt, 4)
    wr(OFS_GEN_CTRL, 32'h0);
    $display("test external wake done");
    base = xs();
    wr(OFS_MEM_BASE, base);
    repeat (8) begin
      off = xs();
      @(posedge core_clk);
      memReqValid <= 1'b1;
      memReqOffset <= off[15:0];
      @(posedge core_clk);
      memReqValid <= 1'b0;
      #1;
      `CHK(memAddr, base + {16'h0000, off[15:0]})
      `CHK(memAddrValid, 1'b1)
    end
    rd(OFS_MEM_BASE, base);
    $display("test memory base done");
    print_verdict();
  end
endmodule
